// ==== inc/cspa_pkg.sv ====
package cspa_pkg;
	// Clock rate and the millisecond base used by all timers
	localparam int CLK_HZ = 50000000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	// Pulse train loss time in milliseconds
	localparam int PULSE_LOSS_MS = 500;
	// Datapath widths and counts
	localparam int CMD_W = 16;
	localparam int WD_W = 16;
	localparam int NUM_PORTS = 4;
	localparam int PORT_W = 2;
	localparam int NUM_SLOTS = 3;
	// Reset value of the command outputs
	localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;

	// Command sources, also the codes held in each priority slot
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_SERIAL = 3'h1,
		SRC_PULSE = 3'h2,
		SRC_ANALOG = 3'h3,
		SRC_CAN = 3'h4,
		SRC_SCRIPT = 3'h5,
		SRC_DEFAULT = 3'h6
	} cspa_src_t;

	// Serial-type ports
	typedef enum logic [1:0] {
		PORT_RS232 = 2'h0,
		PORT_RS485 = 2'h1,
		PORT_TCP = 2'h2,
		PORT_USB = 2'h3
	} cspa_port_t;

	// Command opcodes; only the motion group keeps a source alive
	typedef enum logic [2:0] {
		OP_GOTO = 3'h0,
		OP_STOP_ALL_MODES = 3'h1,
		OP_SET_SPEED = 3'h2,
		OP_TARGET_TORQUE = 3'h3,
		OP_TORQUE_CURRENT = 3'h4,
		OP_FLUX_CURRENT = 3'h5,
		OP_OTHER = 3'h7
	} cspa_op_t;

	// Watchdog-tracked origins
	localparam int ORG_SERIAL = 0;
	localparam int ORG_CAN = 1;
	localparam int ORG_SCRIPT = 2;
	localparam int NUM_ORG = 3;
endpackage : cspa_pkg

// ==== inc/cspa_cmd_if.sv ====
`timescale 1ns/100ps
// One serial command on its way from the port arbiter to the core
interface cspa_cmd_if;
	logic valid;
	logic ready;
	cspa_pkg::cspa_port_t port;
	cspa_pkg::cspa_port_t replyPort;
	cspa_pkg::cspa_op_t op;
	logic [cspa_pkg::CMD_W-1:0] value;
	modport src (output valid, output port, output replyPort, output op, output value,
		input ready);
	modport dst (input valid, input port, input replyPort, input op, input value,
		output ready);
endinterface : cspa_cmd_if

// ==== logic/cspa_serial_fcfs.sv ====
`timescale 1ns/100ps
// First come first served ordering of the serial-type ports
module cspa_serial_fcfs
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [cspa_pkg::NUM_PORTS-1:0] portValid,
	input wire cspa_pkg::cspa_op_t portOp [cspa_pkg::NUM_PORTS],
	input wire logic [cspa_pkg::CMD_W-1:0] portValue [cspa_pkg::NUM_PORTS],
	input wire logic [cspa_pkg::NUM_PORTS-1:0] portRedir,
	input wire cspa_pkg::cspa_port_t portRedirTo [cspa_pkg::NUM_PORTS],
	output logic [cspa_pkg::NUM_PORTS-1:0] portReady,
	cspa_cmd_if.src cmd
);
	// Arrival queue of port numbers, head at index 0
	cspa_pkg::cspa_port_t q [cspa_pkg::NUM_PORTS];
	cspa_pkg::cspa_port_t next_q [cspa_pkg::NUM_PORTS];
	// Number of queued ports, 0 to 4
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	// Port already waiting in the queue
	logic [cspa_pkg::NUM_PORTS-1:0] queued;
	logic [cspa_pkg::NUM_PORTS-1:0] next_queued;
	wire pop = cmd.valid && cmd.ready;
	wire cspa_pkg::cspa_port_t head = q[0];

	// Head of queue is offered; a port waits at most three turns
	assign cmd.valid = (cnt != 3'h0);
	assign cmd.port = head;
	assign cmd.op = portOp[head];
	assign cmd.value = portValue[head];
	assign cmd.replyPort = portRedir[head] ? portRedirTo[head] : head;
	// Ready is a one-cycle grant to the port at the head
	always_comb
	begin
		portReady = '0;
		if (pop)
			portReady[head] = 1'b1;
	end

	// Pop the head, then append newcomers
	always_comb
	begin
		next_q = q;
		next_cnt = cnt;
		next_queued = queued;
		if (pop)
		begin
			for (int i = 0; i < cspa_pkg::NUM_PORTS - 1; i++)
				next_q[i] = q[i+1];
			next_cnt = cnt - 3'h1;
			next_queued[head] = 1'b0;
		end
		// Arrival order kept
		// Same-cycle arrivals go in port number order
		for (int i = 0; i < cspa_pkg::NUM_PORTS; i++)
		begin
			if (portValid[i] && !queued[i])
			begin
				next_q[next_cnt[1:0]] = cspa_pkg::cspa_port_t'(i[1:0]);
				next_cnt = next_cnt + 3'h1;
				next_queued[i] = 1'b1;
			end
		end
	end

	// Queue state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < cspa_pkg::NUM_PORTS; i++)
				q[i] <= cspa_pkg::PORT_RS232;
			cnt <= 3'h0;
			queued <= '0;
		end
		else
		begin
			q <= next_q;
			cnt <= next_cnt;
			queued <= next_queued;
		end
	end
endmodule : cspa_serial_fcfs

// ==== logic/cspa_source_arbiter.sv ====
`timescale 1ns/100ps
// Overview of operation
// - Any mix of sources may be enabled
// - Three-slot user priority table
// - First slot source used when active
// - Inactive slot falls to the next slot
// - No active slot gives the default command
// - Serial active while motion commands keep arriving
// - Watchdog expiry drops serial at once
// - Watchdog off keeps serial active forever
// - Script and CAN motion commands credited separately
// - Pulse active while valid pulses present
// - Analog active, optionally after first centering
// - Analog out of range made inactive
// - Slot set to none is skipped
// - Serial ports served in arrival order
// - Reply goes to the arrival port
// - Redirection marker picks another reply port
// - CAN beats all but the script
// - Script beats every other source
// - Pulse lost after 500 ms without pulses
module cspa_source_arbiter
#(
	parameter int NUM_PULSE = 2,
	parameter int CYC_PER_MS = cspa_pkg::CYC_PER_MS,
	parameter int PULSE_LOSS_MS = cspa_pkg::PULSE_LOSS_MS
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [cspa_pkg::NUM_PORTS-1:0] portValid,
	input wire cspa_pkg::cspa_op_t portOp [cspa_pkg::NUM_PORTS],
	input wire logic [cspa_pkg::CMD_W-1:0] portValue [cspa_pkg::NUM_PORTS],
	input wire logic [cspa_pkg::NUM_PORTS-1:0] portRedir,
	input wire cspa_pkg::cspa_port_t portRedirTo [cspa_pkg::NUM_PORTS],
	output logic [cspa_pkg::NUM_PORTS-1:0] portReady,
	input wire logic canValid,
	input wire cspa_pkg::cspa_op_t canOp,
	input wire logic [cspa_pkg::CMD_W-1:0] canValue,
	input wire logic scriptValid,
	input wire cspa_pkg::cspa_op_t scriptOp,
	input wire logic [cspa_pkg::CMD_W-1:0] scriptValue,
	input wire logic [NUM_PULSE-1:0] pulseGood,
	input wire logic [NUM_PULSE-1:0] pulseEnable,
	input wire logic [cspa_pkg::CMD_W-1:0] pulseValue,
	input wire logic signed [cspa_pkg::CMD_W-1:0] analogValue,
	input wire logic centerSafeEn,
	input wire logic [cspa_pkg::CMD_W-1:0] centerBand,
	input wire logic rangeSafeEn,
	input wire logic signed [cspa_pkg::CMD_W-1:0] analogMin,
	input wire logic signed [cspa_pkg::CMD_W-1:0] analogMax,
	input wire cspa_pkg::cspa_src_t prioSlot [cspa_pkg::NUM_SLOTS],
	input wire logic [cspa_pkg::CMD_W-1:0] defaultCmd,
	input wire logic [cspa_pkg::WD_W-1:0] watchdogMs,
	output logic [cspa_pkg::CMD_W-1:0] motorCmd,
	output cspa_pkg::cspa_src_t activeSrc,
	output logic serialActive,
	output logic pulseActive,
	output logic analogActive,
	output logic canActive,
	output logic scriptActive,
	output logic execValid,
	output cspa_pkg::cspa_op_t execOp,
	output logic [cspa_pkg::CMD_W-1:0] execValue,
	output cspa_pkg::cspa_port_t replyPort,
	output cspa_pkg::cspa_port_t arrivalPort
);
	localparam int MS_CNT_W = $clog2(CYC_PER_MS);
	localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(CYC_PER_MS - 1);
	localparam int LOSS_W = $clog2(PULSE_LOSS_MS + 2);
	localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(PULSE_LOSS_MS);

	// True for the command group that keeps a source alive
	function automatic logic isMotion(input cspa_pkg::cspa_op_t op);
		case (op)
			cspa_pkg::OP_GOTO,
			cspa_pkg::OP_STOP_ALL_MODES,
			cspa_pkg::OP_SET_SPEED,
			cspa_pkg::OP_TARGET_TORQUE,
			cspa_pkg::OP_TORQUE_CURRENT,
			cspa_pkg::OP_FLUX_CURRENT:
				isMotion = 1'b1;
			default:
				isMotion = 1'b0;
		endcase
	endfunction : isMotion

	// Value a motion command asks for; stop-all always asks for zero
	function automatic logic [cspa_pkg::CMD_W-1:0] cmdValue(input cspa_pkg::cspa_op_t op,
		input logic [cspa_pkg::CMD_W-1:0] v);
		cmdValue = (op == cspa_pkg::OP_STOP_ALL_MODES) ? cspa_pkg::CMD_RESET : v;
	endfunction : cmdValue

	// Serial commands in arrival order
	cspa_cmd_if cmdBus ();

	cspa_serial_fcfs uFcfs
	(
		.clk(clk),
		.rst_n(rst_n),
		.portValid(portValid),
		.portOp(portOp),
		.portValue(portValue),
		.portRedir(portRedir),
		.portRedirTo(portRedirTo),
		.portReady(portReady),
		.cmd(cmdBus)
	);

	// The core executes one serial command per cycle, never stalls
	assign cmdBus.ready = 1'b1;
	wire serialTake = cmdBus.valid;

	// Millisecond tick shared by all timers
	logic [MS_CNT_W-1:0] msCnt;
	wire msTick = (msCnt == MS_LAST);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			msCnt <= '0;
		else
			msCnt <= msTick ? '0 : msCnt + MS_CNT_W'(1);
	end

	// Motion command seen per origin, serial, CAN and script
	wire [cspa_pkg::NUM_ORG-1:0] motionHit;
	assign motionHit[cspa_pkg::ORG_SERIAL] = serialTake && isMotion(cmdBus.op);
	assign motionHit[cspa_pkg::ORG_CAN] = canValid && isMotion(canOp);
	assign motionHit[cspa_pkg::ORG_SCRIPT] = scriptValid && isMotion(scriptOp);

	// Watchdog off when the timeout is zero
	wire watchdogOff = (watchdogMs == '0);
	// Remaining watchdog time per origin, in milliseconds
	logic [cspa_pkg::WD_W-1:0] wdCnt [cspa_pkg::NUM_ORG];
	// Origin has had at least one motion command
	logic [cspa_pkg::NUM_ORG-1:0] seen;
	wire [cspa_pkg::NUM_ORG-1:0] orgActive;

	// Watchdog per origin; a fresh command wins over the tick
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < cspa_pkg::NUM_ORG; i++)
				wdCnt[i] <= '0;
			seen <= '0;
		end
		else
		begin
			for (int i = 0; i < cspa_pkg::NUM_ORG; i++)
			begin
				if (motionHit[i])
				begin
					wdCnt[i] <= watchdogMs;
					seen[i] <= 1'b1;
				end
				else if (msTick && wdCnt[i] != '0)
					wdCnt[i] <= wdCnt[i] - cspa_pkg::WD_W'(1);
			end
		end
	end

	// Watchdog disabled keeps a seen origin active
	// Activity follows the counter with no extra delay
	for (genvar g = 0; g < cspa_pkg::NUM_ORG; g++)
	begin : gAct
		assign orgActive[g] = seen[g] && (watchdogOff || wdCnt[g] != '0);
	end

	// Latest motion value per origin
	logic [cspa_pkg::CMD_W-1:0] serialCmd;
	logic [cspa_pkg::CMD_W-1:0] canCmd;
	logic [cspa_pkg::CMD_W-1:0] scriptCmd;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serialCmd <= cspa_pkg::CMD_RESET;
			canCmd <= cspa_pkg::CMD_RESET;
			scriptCmd <= cspa_pkg::CMD_RESET;
		end
		else
		begin
			if (motionHit[cspa_pkg::ORG_SERIAL])
				serialCmd <= cmdValue(cmdBus.op, cmdBus.value);
			if (motionHit[cspa_pkg::ORG_CAN])
				canCmd <= cmdValue(canOp, canValue);
			if (motionHit[cspa_pkg::ORG_SCRIPT])
				scriptCmd <= cmdValue(scriptOp, scriptValue);
		end
	end

	// Pulse train presence on enabled inputs only
	wire pulseHit = |(pulseGood & pulseEnable);
	// Milliseconds since the last valid pulse, saturating above the limit
	logic [LOSS_W-1:0] lossMs;
	logic pulseSeen;
	logic [cspa_pkg::CMD_W-1:0] pulseCmd;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lossMs <= '0;
			pulseSeen <= 1'b0;
			pulseCmd <= cspa_pkg::CMD_RESET;
		end
		else if (pulseHit)
		begin
			// A pulse wins over a tick in the same cycle
			lossMs <= '0;
			pulseSeen <= 1'b1;
			pulseCmd <= pulseValue;
		end
		else if (msTick && lossMs <= LOSS_LIMIT)
			lossMs <= lossMs + LOSS_W'(1);
	end

	wire pulseOk = pulseSeen && (pulseEnable != '0) && (lossMs <= LOSS_LIMIT);

	// Magnitude of the analog input for the centre test
	wire [cspa_pkg::CMD_W-1:0] analogMag = analogValue[cspa_pkg::CMD_W-1] ?
		cspa_pkg::CMD_W'(-analogValue) : analogValue;
	wire inCenter = (analogMag <= centerBand);
	// Joystick has been centred at least once since reset
	logic centered;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			centered <= 1'b0;
		else if (inCenter)
			centered <= 1'b1;
	end

	wire centerOk = !centerSafeEn || centered;
	wire rangeOk = !rangeSafeEn || (analogValue >= analogMin && analogValue <= analogMax);
	wire analogOk = centerOk && rangeOk;

	// Activity of each prioritised source, indexed by source code
	function automatic logic srcOk(input cspa_pkg::cspa_src_t s, input logic ser,
		input logic pul, input logic ana);
		case (s)
			cspa_pkg::SRC_SERIAL:
				srcOk = ser;
			cspa_pkg::SRC_PULSE:
				srcOk = pul;
			cspa_pkg::SRC_ANALOG:
				srcOk = ana;
			default:
				srcOk = 1'b0;
		endcase
	endfunction : srcOk

	// Slot state, recomputed every cycle so a recovered source takes over
	wire [cspa_pkg::NUM_SLOTS-1:0] slotOk;
	for (genvar g = 0; g < cspa_pkg::NUM_SLOTS; g++)
	begin : gSlot
		assign slotOk[g] = srcOk(prioSlot[g], orgActive[cspa_pkg::ORG_SERIAL], pulseOk,
			analogOk);
	end

	// Winning source: script, then CAN, then the three slots, then default
	logic [cspa_pkg::CMD_W-1:0] next_cmd;
	cspa_pkg::cspa_src_t next_src;
	// Slot source to feed, once slot priority is resolved
	cspa_pkg::cspa_src_t slotSrc;
	assign slotSrc = slotOk[0] ? prioSlot[0] : slotOk[1] ? prioSlot[1] :
		slotOk[2] ? prioSlot[2] : cspa_pkg::SRC_DEFAULT;

	always_comb
	begin
		next_src = slotSrc;
		next_cmd = defaultCmd;
		if (orgActive[cspa_pkg::ORG_SCRIPT])
		begin
			next_src = cspa_pkg::SRC_SCRIPT;
			next_cmd = scriptCmd;
		end
		else if (orgActive[cspa_pkg::ORG_CAN])
		begin
			next_src = cspa_pkg::SRC_CAN;
			next_cmd = canCmd;
		end
		else
		begin
			case (slotSrc)
				cspa_pkg::SRC_SERIAL:
					next_cmd = serialCmd;
				cspa_pkg::SRC_PULSE:
					next_cmd = pulseCmd;
				cspa_pkg::SRC_ANALOG:
					next_cmd = analogValue;
				default:
					next_cmd = defaultCmd;
			endcase
		end
	end

	// Registered command and source outputs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			motorCmd <= cspa_pkg::CMD_RESET;
			activeSrc <= cspa_pkg::SRC_NONE;
			serialActive <= 1'b0;
			pulseActive <= 1'b0;
			analogActive <= 1'b0;
			canActive <= 1'b0;
			scriptActive <= 1'b0;
		end
		else
		begin
			motorCmd <= next_cmd;
			activeSrc <= next_src;
			serialActive <= orgActive[cspa_pkg::ORG_SERIAL];
			pulseActive <= pulseOk;
			analogActive <= analogOk;
			canActive <= orgActive[cspa_pkg::ORG_CAN];
			scriptActive <= orgActive[cspa_pkg::ORG_SCRIPT];
		end
	end

	// Executed serial command with its reply routing, one cycle per command
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			execValid <= 1'b0;
			execOp <= cspa_pkg::OP_OTHER;
			execValue <= cspa_pkg::CMD_RESET;
			replyPort <= cspa_pkg::PORT_RS232;
			arrivalPort <= cspa_pkg::PORT_RS232;
		end
		else
		begin
			execValid <= serialTake;
			if (serialTake)
			begin
				execOp <= cmdBus.op;
				execValue <= cmdBus.value;
				replyPort <= cmdBus.replyPort;
				arrivalPort <= cmdBus.port;
			end
		end
	end
endmodule : cspa_source_arbiter

// ==== test/cspa_chk.sv ====
`timescale 1ns/100ps
// Watches the arbiter from its top ports only
module cspa_chk
#(
	parameter int NUM_PULSE = 2,
	parameter int CYC_PER_MS = 10,
	parameter int PULSE_LOSS_MS = 5
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] portValid,
	input wire logic [3:0] portRedir,
	input wire cspa_pkg::cspa_port_t portRedirTo [4],
	input wire logic [3:0] portReady,
	input wire logic [NUM_PULSE-1:0] pulseGood,
	input wire logic [NUM_PULSE-1:0] pulseEnable,
	input wire logic signed [15:0] analogValue,
	input wire logic rangeSafeEn,
	input wire logic signed [15:0] analogMin,
	input wire logic signed [15:0] analogMax,
	input wire logic [15:0] defaultCmd,
	input wire logic [15:0] motorCmd,
	input wire cspa_pkg::cspa_src_t activeSrc,
	input wire logic pulseActive,
	input wire logic analogActive,
	input wire logic canActive,
	input wire logic scriptActive,
	input wire logic execValid,
	input wire cspa_pkg::cspa_port_t replyPort,
	input wire cspa_pkg::cspa_port_t arrivalPort
);
	// Slack covers the free-running ms tick and the output register
	localparam int LOSS_MAX = (PULSE_LOSS_MS + 2) * CYC_PER_MS + 2;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Any enabled capture restarts the loss count
	wire gotPulse = |(pulseGood & pulseEnable);
	wire outRange = rangeSafeEn && (analogValue < analogMin || analogValue > analogMax);
	// Port served this cycle and where its reply should go
	wire [1:0] rdyIdx = portReady[3] ? 2'h3 : portReady[2] ? 2'h2 : {1'b0, portReady[1]};
	wire redirOn = portRedir[rdyIdx];
	wire [1:0] redirTo = portRedirTo[rdyIdx];
	int idleCnt; // Cycles since the last enabled pulse, saturating
	// Saturate so the counter never wraps during long idle runs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			idleCnt <= 0;
		else if (gotPulse)
			idleCnt <= 0;
		else if (idleCnt <= LOSS_MAX)
			idleCnt <= idleCnt + 1;
	end
	sequence sTaken;
		|portReady;
	endsequence
	sequence sExec;
		##1 execValid;
	endsequence
	a_ready_single: assert property ($onehot0(portReady))
		else $error("two ports served in one cycle");
	a_ready_valid: assert property ((portReady & ~portValid) == 4'h0)
		else $error("port served without a command");
	a_exec_next: assert property (sTaken |-> sExec)
		else $error("served command not executed next cycle");
	a_arrival_port: assert property (sTaken |=> arrivalPort == $past(rdyIdx))
		else $error("wrong arrival port");
	a_reply_route: assert property (sTaken |=>
		replyPort == ($past(redirOn) ? $past(redirTo) : $past(rdyIdx)))
		else $error("wrong reply port");
	a_script_top: assert property (scriptActive && $past(scriptActive)
		|-> activeSrc == cspa_pkg::SRC_SCRIPT)
		else $error("script did not win");
	a_can_next: assert property (canActive && $past(canActive) && !scriptActive
		&& !$past(scriptActive) |-> activeSrc == cspa_pkg::SRC_CAN)
		else $error("can did not win");
	a_default_cmd: assert property (activeSrc == cspa_pkg::SRC_DEFAULT
		&& $stable(defaultCmd) |-> motorCmd == defaultCmd)
		else $error("default command not applied");
	a_pulse_loss: assert property (pulseActive |-> idleCnt <= LOSS_MAX)
		else $error("pulse source kept after loss");
	a_pulse_cause: assert property ($rose(pulseActive) |-> idleCnt <= 3)
		else $error("pulse source active without pulses");
	a_range_off: assert property (outRange && $past(outRange) |-> !analogActive)
		else $error("analog active out of range");
endmodule : cspa_chk
bind cspa_source_arbiter cspa_chk #(.NUM_PULSE(NUM_PULSE), .CYC_PER_MS(CYC_PER_MS),
	.PULSE_LOSS_MS(PULSE_LOSS_MS)) chk (.clk(clk), .rst_n(rst_n), .portValid(portValid),
	.portRedir(portRedir), .portRedirTo(portRedirTo), .portReady(portReady),
	.pulseGood(pulseGood), .pulseEnable(pulseEnable), .analogValue(analogValue),
	.rangeSafeEn(rangeSafeEn), .analogMin(analogMin), .analogMax(analogMax),
	.defaultCmd(defaultCmd), .motorCmd(motorCmd), .activeSrc(activeSrc),
	.pulseActive(pulseActive), .analogActive(analogActive), .canActive(canActive),
	.scriptActive(scriptActive), .execValid(execValid), .replyPort(replyPort),
	.arrivalPort(arrivalPort));

// ==== test/cspa_host_model.sv ====
`timescale 1ns/100ps
// Host side of the four serial-type ports
module cspa_host_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] go,
	input wire cspa_pkg::cspa_op_t op,
	input wire logic [15:0] value,
	input wire logic [3:0] redir,
	input wire cspa_pkg::cspa_port_t redirTo,
	input wire logic [3:0] portReady,
	output logic [3:0] portValid,
	output cspa_pkg::cspa_op_t portOp [4],
	output logic [15:0] portValue [4],
	output logic [3:0] portRedir,
	output cspa_pkg::cspa_port_t portRedirTo [4]
);
	// Each port holds its command until served; a released value is inverted
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			portValid <= 4'h0;
			portRedir <= 4'h0;
			for (int i = 0; i < 4; i++)
			begin
				portOp[i] <= cspa_pkg::OP_OTHER;
				portValue[i] <= 16'h0000;
				portRedirTo[i] <= cspa_pkg::PORT_RS232;
			end
		end
		else
			for (int i = 0; i < 4; i++)
			begin
				// New command only on an idle port, so fields stay stable
				if (go[i] && !portValid[i])
				begin
					portValid[i] <= 1'b1;
					portOp[i] <= op;
					portValue[i] <= value;
					portRedir[i] <= redir[i];
					portRedirTo[i] <= redirTo;
				end
				else if (portValid[i] && portReady[i])
				begin
					portValid[i] <= 1'b0;
					portValue[i] <= ~portValue[i];
				end
			end
	end
endmodule : cspa_host_model

// ==== test/command_source_priority_arbiter_tb_top.sv ====
`timescale 1ns/100ps
// Bench for the command source arbiter
module command_source_priority_arbiter_tb_top;
	logic clk, rst_n, canValid, scriptValid, centerSafeEn, rangeSafeEn;
	logic [3:0] go, redir, portValid, portReady, portRedir;
	logic [15:0] value, canValue, scriptValue, pulseValue, centerBand, defaultCmd;
	logic [15:0] watchdogMs, motorCmd, execValue;
	logic signed [15:0] analogValue, analogMin, analogMax;
	logic [1:0] pulseGood, pulseEnable;
	logic serialActive, pulseActive, analogActive, canActive, scriptActive, execValid;
	cspa_pkg::cspa_op_t op, canOp, scriptOp, execOp, portOp [4];
	cspa_pkg::cspa_port_t redirTo, replyPort, arrivalPort, portRedirTo [4];
	cspa_pkg::cspa_src_t activeSrc, prioSlot [3];
	logic [15:0] portValue [4];
	logic [1:0] arrQ [$], repQ [$]; // Executed ports, in order
	int fail_count, checks;
	cspa_host_model host (.clk(clk), .rst_n(rst_n), .go(go), .op(op), .value(value),
		.redir(redir), .redirTo(redirTo), .portReady(portReady), .portValid(portValid),
		.portOp(portOp), .portValue(portValue), .portRedir(portRedir),
		.portRedirTo(portRedirTo));
	// Short ms base and loss time keep the run brief
	cspa_source_arbiter #(.NUM_PULSE(2), .CYC_PER_MS(10), .PULSE_LOSS_MS(5)) dut (
		.clk(clk), .rst_n(rst_n), .portValid(portValid), .portOp(portOp),
		.portValue(portValue), .portRedir(portRedir), .portRedirTo(portRedirTo),
		.portReady(portReady), .canValid(canValid), .canOp(canOp), .canValue(canValue),
		.scriptValid(scriptValid), .scriptOp(scriptOp), .scriptValue(scriptValue),
		.pulseGood(pulseGood), .pulseEnable(pulseEnable), .pulseValue(pulseValue),
		.analogValue(analogValue), .centerSafeEn(centerSafeEn), .centerBand(centerBand),
		.rangeSafeEn(rangeSafeEn), .analogMin(analogMin), .analogMax(analogMax),
		.prioSlot(prioSlot), .defaultCmd(defaultCmd), .watchdogMs(watchdogMs),
		.motorCmd(motorCmd), .activeSrc(activeSrc), .serialActive(serialActive),
		.pulseActive(pulseActive), .analogActive(analogActive), .canActive(canActive),
		.scriptActive(scriptActive), .execValid(execValid), .execOp(execOp),
		.execValue(execValue), .replyPort(replyPort), .arrivalPort(arrivalPort));
	always #10 clk = ~clk;
	// Log executions at the edge, before the pulse is cleared
	always @(posedge clk)
		if (execValid === 1'b1)
		begin
			arrQ.push_back(arrivalPort);
			repQ.push_back(replyPort);
		end
	task automatic summarize();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic cmpVal(input logic [15:0] exp, input logic [15:0] act);
		checks++;
		if (act !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t exp=%h act=%h", $time, exp, act);
		end
	endtask : cmpVal
	// Bounded wait for a source; a timeout ends the run
	task automatic expectSrc(input cspa_pkg::cspa_src_t exp, input int n);
		int k;
		k = 0;
		repeat (3) @(posedge clk);
		#1;
		while (activeSrc !== exp && k < n)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		cmpVal({13'h0, exp}, {13'h0, activeSrc});
		if (activeSrc !== exp)
			summarize();
	endtask : expectSrc
	// Starts commands on the masked ports with one go pulse
	task automatic send(input logic [3:0] m, input cspa_pkg::cspa_op_t o,
		input logic [15:0] v, input logic [3:0] r);
		@(posedge clk);
		go <= m;
		op <= o;
		value <= v;
		redir <= r;
		@(posedge clk);
		go <= 4'h0;
	endtask : send
	task automatic waitExec(input int n);
		int k;
		for (k = 0; k < 40 && arrQ.size() < n; k++)
			@(posedge clk);
		#1;
		cmpVal(16'(n), 16'(arrQ.size()));
		if (arrQ.size() < n)
			summarize();
	endtask : waitExec
	initial
	begin
		clk = 0; rst_n = 0; go = 0; op = cspa_pkg::OP_OTHER; value = 0; redir = 0;
		redirTo = cspa_pkg::PORT_USB; canValid = 0; canOp = cspa_pkg::OP_GOTO; canValue = 0;
		scriptValid = 0; scriptOp = cspa_pkg::OP_SET_SPEED; scriptValue = 0; pulseGood = 0;
		pulseEnable = 2'h3; pulseValue = 0; analogValue = 16'h0040; centerSafeEn = 0;
		centerBand = 16'h0010; rangeSafeEn = 0; analogMin = 16'hff9c; analogMax = 16'h0064;
		prioSlot = '{cspa_pkg::SRC_SERIAL, cspa_pkg::SRC_PULSE, cspa_pkg::SRC_ANALOG};
		defaultCmd = 16'h0abc; watchdogMs = 16'h0003; fail_count = 0; checks = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1;
		expectSrc(cspa_pkg::SRC_ANALOG, 4);
		cmpVal(16'h0040, motorCmd);
		// Analog outside the safe range falls to the default
		@(posedge clk);
		analogValue <= 16'h0200;
		rangeSafeEn <= 1;
		expectSrc(cspa_pkg::SRC_DEFAULT, 4);
		cmpVal(16'h0abc, motorCmd);
		@(posedge clk);
		analogValue <= 16'h0040;
		pulseValue <= 16'h0123;
		pulseGood <= 2'h2;
		@(posedge clk);
		pulseGood <= 2'h0;
		expectSrc(cspa_pkg::SRC_PULSE, 4);
		cmpVal(16'h0123, motorCmd);
		@(posedge clk);
		prioSlot[1] <= cspa_pkg::SRC_NONE;
		expectSrc(cspa_pkg::SRC_ANALOG, 4);
		@(posedge clk);
		prioSlot[1] <= cspa_pkg::SRC_PULSE;
		expectSrc(cspa_pkg::SRC_PULSE, 4);
		expectSrc(cspa_pkg::SRC_ANALOG, 100);
		// A non-motion command is served but does not activate serial
		send(4'h2, cspa_pkg::OP_OTHER, 16'h0999, 4'h0);
		waitExec(1);
		cmpVal(16'h0001, {14'h0, arrQ[0]});
		cmpVal(16'h0001, {14'h0, repQ[0]});
		cmpVal(16'h0999, execValue);
		cmpVal({13'h0, cspa_pkg::OP_OTHER}, {13'h0, execOp});
		cmpVal({13'h0, cspa_pkg::SRC_ANALOG}, {13'h0, activeSrc});
		// USB first, then RS232 with redirection and TCP in one cycle
		send(4'h8, cspa_pkg::OP_TORQUE_CURRENT, 16'h0111, 4'h0);
		send(4'h5, cspa_pkg::OP_FLUX_CURRENT, 16'h0222, 4'h1);
		waitExec(4);
		cmpVal(16'h3023, {2'h0, arrQ[1], 2'h0, arrQ[2], 2'h0, arrQ[3], 4'h3});
		cmpVal(16'h3323, {2'h0, repQ[1], 2'h0, repQ[2], 2'h0, repQ[3], 4'h3});
		expectSrc(cspa_pkg::SRC_SERIAL, 8);
		cmpVal(16'h0222, motorCmd);
		expectSrc(cspa_pkg::SRC_ANALOG, 60);
		// CAN command is credited to CAN, not to serial
		@(posedge clk);
		canOp <= cspa_pkg::OP_TARGET_TORQUE;
		canValue <= 16'h0333;
		canValid <= 1;
		@(posedge clk);
		canValid <= 0;
		expectSrc(cspa_pkg::SRC_CAN, 4);
		cmpVal(16'h0333, motorCmd);
		cmpVal(16'h0000, {15'h0, serialActive});
		// Script lands at the edge that takes the serial command: script wins
		send(4'h1, cspa_pkg::OP_GOTO, 16'h0555, 4'h0);
		@(posedge clk);
		scriptValue <= 16'h0444;
		scriptValid <= 1;
		@(posedge clk);
		scriptValid <= 0;
		expectSrc(cspa_pkg::SRC_SCRIPT, 6);
		repeat (6) @(posedge clk);
		#1;
		cmpVal(16'h0444, motorCmd);
		expectSrc(cspa_pkg::SRC_ANALOG, 80);
		// Second reset with the centring safety on
		@(posedge clk);
		rst_n <= 0;
		centerSafeEn <= 1;
		rangeSafeEn <= 0;
		analogValue <= 16'h0200;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		expectSrc(cspa_pkg::SRC_DEFAULT, 4);
		cmpVal(16'h0000, {15'h0, analogActive});
		@(posedge clk);
		analogValue <= 16'h0005;
		expectSrc(cspa_pkg::SRC_ANALOG, 4);
		@(posedge clk);
		analogValue <= 16'h0200;
		repeat (4) @(posedge clk);
		#1;
		cmpVal(16'h0200, motorCmd);
		// Watchdog off keeps serial for good; reset cleared older script and CAN
		@(posedge clk);
		watchdogMs <= 16'h0000;
		send(4'h4, cspa_pkg::OP_SET_SPEED, 16'h0666, 4'h0);
		expectSrc(cspa_pkg::SRC_SERIAL, 8);
		cmpVal(16'h0666, motorCmd);
		send(4'h2, cspa_pkg::OP_STOP_ALL_MODES, 16'h0777, 4'h0);
		repeat (200) @(posedge clk);
		#1;
		cmpVal(16'h0000, motorCmd);
		cmpVal({13'h0, cspa_pkg::SRC_SERIAL}, {13'h0, activeSrc});
		summarize();
	end
endmodule : command_source_priority_arbiter_tb_top
